// ### pkg/fpau_pkg.sv
// Purpose: constants for the fixed-point abs/add slice
// Assumes: 32-bit instruction word, bit 0 is the most significant bit
// Notes: bit numbers below are verilog indices (31 - printed position)
package fpau_pkg;
   localparam int DATA_W = 32;
   localparam int REG_AW = 5;
   localparam logic [5:0] PRIMARY_OP = 6'h1f;
   localparam logic [8:0] EXT_ABS = 9'h168;
   localparam logic [8:0] EXT_ADD = 9'h10a;
   // field positions, verilog numbering
   localparam int PRI_HI = 31;
   localparam int PRI_LO = 26;
   localparam int DST_HI = 25;
   localparam int DST_LO = 21;
   localparam int SRC1_HI = 20;
   localparam int SRC1_LO = 16;
   localparam int SRC2_HI = 15;
   localparam int SRC2_LO = 11;
   localparam int OE_POS = 10;
   localparam int EXT_HI = 9;
   localparam int EXT_LO = 1;
   localparam int REC_POS = 0;
   localparam logic [31:0] MOST_NEG = 32'h8000_0000;
   localparam logic [3:0] CR0_RESET = 4'h0;
   localparam logic OLD_ARCH_DEFAULT = 1'b1;
endpackage

// ### design/fpau_decode.sv
// Purpose: split an instruction word into fields and classify it
// Assumes: word is stable while issue is high
// Notes: purely combinational
`timescale 1ns/1ps
module fpau_decode (
   // instruction in
   input wire logic [31:0] instr,
   input wire logic old_arch,
   // decoded fields
   output logic [4:0] dest_register_field,
   output logic [4:0] first_source_field,
   output logic [4:0] second_source_field,
   output logic oe_bit,
   output logic record_bit,
   output logic is_abs,
   output logic is_add
);
   logic pri_ok;
   logic [8:0] ext;
   always_comb begin
      pri_ok = instr[fpau_pkg::PRI_HI:fpau_pkg::PRI_LO] == fpau_pkg::PRIMARY_OP;
      ext = instr[fpau_pkg::EXT_HI:fpau_pkg::EXT_LO];
      dest_register_field = instr[fpau_pkg::DST_HI:fpau_pkg::DST_LO];
      first_source_field = instr[fpau_pkg::SRC1_HI:fpau_pkg::SRC1_LO];
      second_source_field = instr[fpau_pkg::SRC2_HI:fpau_pkg::SRC2_LO];
      oe_bit = instr[fpau_pkg::OE_POS];
      record_bit = instr[fpau_pkg::REC_POS];
      // abs exists only on the older variant
      is_abs = pri_ok && ext == fpau_pkg::EXT_ABS && old_arch;
      // both add spellings share one encoding
      is_add = pri_ok && ext == fpau_pkg::EXT_ADD;
   end
endmodule

// ### design/fpau_arith.sv
// Purpose: abs and add result with signed-overflow detect
// Assumes: operands already read from the register file
// Notes: combinational; no carry output by design
`timescale 1ns/1ps
module fpau_arith #(
   parameter int W = 32
) (
   // operands
   input wire logic [W-1:0] opa,
   input wire logic [W-1:0] opb,
   input wire logic sel_abs,
   // result
   output logic [W-1:0] result,
   output logic ovf
);
   logic [W-1:0] sum;
   logic [W-1:0] neg;
   always_comb begin
      sum = opa + opb;
      neg = ~opa + {{(W-1){1'b0}}, 1'b1};
      if (sel_abs) begin
         // most negative negates to itself
         result = opa[W-1] ? neg : opa;
         ovf = opa == {1'b1, {(W-1){1'b0}}};
      end else begin
         result = sum;
         ovf = (opa[W-1] == opb[W-1]) && (sum[W-1] != opa[W-1]);
      end
   end
endmodule

// ### design/fpau_top.sv
// Purpose: fixed-point abs / add execution slice
// Assumes: register file outside, read combinationally via address ports
// Notes: one instruction per issue pulse, result one cycle later
// =====================================================================
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module fpau_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // issue
   input wire logic issue,
   input wire logic [31:0] instr,
   input wire logic old_arch,
   // register file read
   output logic [4:0] rd_addr_a,
   output logic [4:0] rd_addr_b,
   input wire logic [31:0] rd_data_a,
   input wire logic [31:0] rd_data_b,
   // register file write
   output logic wr_en_q,
   output logic [4:0] wr_addr_q,
   output logic [31:0] wr_data_q,
   // status
   output logic illegal_q,
   output logic unsigned_wrap_bit_q,
   output logic signed_wrap_flag_q,
   output logic summary_q,
   output logic [3:0] cr0_q,
   output logic irq_q,
   // carry preload and interrupt control
   input wire logic ca_load,
   input wire logic ca_value,
   input wire logic [1:0] irq_mask,
   input wire logic status_rd
);
   logic [4:0] dst;
   logic oe;
   logic rec;
   logic is_abs;
   logic is_add;
   logic [31:0] res;
   logic ovf;
   logic valid;
   logic so_next;
   logic [1:0] evt_q;
   logic [1:0] evt_new;

   // =====================================================================
   // decode and datapath
   fpau_decode u_dec (
      .instr(instr),
      .old_arch(old_arch),
      .dest_register_field(dst),
      .first_source_field(rd_addr_a),
      .second_source_field(rd_addr_b),
      .oe_bit(oe),
      .record_bit(rec),
      .is_abs(is_abs),
      .is_add(is_add)
   );

   fpau_arith #(.W(fpau_pkg::DATA_W)) u_alu (
      .opa(rd_data_a),
      .opb(rd_data_b),
      .sel_abs(is_abs),
      .result(res),
      .ovf(ovf)
   );

   always_comb begin
      valid = issue && (is_abs || is_add);
      so_next = summary_q | (oe & ovf);
   end

   // =====================================================================
   // result write-back
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_en_q <= 1'b0;
         wr_addr_q <= 5'h00;
         wr_data_q <= 32'h0000_0000;
      end else begin
         wr_en_q <= valid;
         if (valid) begin
            wr_addr_q <= dst;
            wr_data_q <= res;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         illegal_q <= 1'b0;
      end else begin
         // abs on the newer variant lands here
         illegal_q <= issue && !valid;
      end
   end

   // =====================================================================
   // exception register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         unsigned_wrap_bit_q <= 1'b0;
      end else if (ca_load) begin
         // neither operation writes carry; only software preload
         unsigned_wrap_bit_q <= ca_value;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         signed_wrap_flag_q <= 1'b0;
         summary_q <= 1'b0;
      end else if (valid && oe) begin
         signed_wrap_flag_q <= ovf;
         summary_q <= so_next;
      end
   end

   // =====================================================================
   // condition field 0: negative, positive, zero, summary
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cr0_q <= fpau_pkg::CR0_RESET;
      end else if (valid && rec) begin
         cr0_q <= {res[31], !res[31] && res != 32'h0000_0000,
                   res == 32'h0000_0000, so_next};
      end
   end

   // =====================================================================
   // interrupts: bit0 overflow, bit1 illegal; read clears, set wins
   always_comb begin
      evt_new = {issue && !valid, valid && oe && ovf};
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         evt_q <= 2'h0;
      end else if (status_rd) begin
         evt_q <= evt_new;
      end else begin
         evt_q <= evt_q | evt_new;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |((status_rd ? evt_new : (evt_q | evt_new)) & irq_mask);
      end
   end
endmodule

// ### testbench/fpau_chk.sv
// Purpose: port checks. Assumes: one clock. Notes: bound in bench.
`timescale 1ns/1ps
module fpau_chk (
   // top ports
   input wire logic clk_sys, rst_n, issue, old_arch, ca_load, wr_en_q,
   input wire logic illegal_q, summary_q, input wire logic [4:0] wr_addr_q,
   input wire logic unsigned_wrap_bit_q, signed_wrap_flag_q,
   input wire logic [3:0] cr0_q,
   input wire logic [31:0] instr, rd_data_a, rd_data_b, wr_data_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire op_i = issue && instr[31:26] == fpau_pkg::PRIMARY_OP;
   wire add_i = op_i && instr[9:1] == fpau_pkg::EXT_ADD;
   wire ab_i = op_i && instr[9:1] == fpau_pkg::EXT_ABS;
   wire [31:0] s = rd_data_a + rd_data_b;
   wire [31:0] mg = rd_data_a[31] ? -rd_data_a : rd_data_a;
   logic [31:0] ins_q;
   always_ff @(posedge clk_sys) ins_q <= instr;
   add_sum_a: assert property (add_i |=> wr_data_q == $past(s))
      else $error("bad sum");
   abs_mag_a: assert property (ab_i && old_arch |=>
      wr_data_q == $past(mg)) else $error("bad abs");
   abs_old_a: assert property (ab_i && !old_arch |=>
      illegal_q && !wr_en_q) else $error("abs ran");
   oe_gate_a: assert property (issue && !instr[10] |=>
      $stable(signed_wrap_flag_q) && $stable(summary_q))
      else $error("wrap moved");
   so_sticky_a: assert property (summary_q |=> summary_q)
      else $error("summary fell");
   carry_hold_a: assert property (!ca_load |=>
      $stable(unsigned_wrap_bit_q)) else $error("carry moved");
   cr0_rec_a: assert property (wr_en_q && ins_q[0] |->
      cr0_q == {wr_data_q[31], !wr_data_q[31] && |wr_data_q,
      wr_data_q == 32'h0, summary_q}) else $error("bad cr0");
   dest_sel_a: assert property (wr_en_q |->
      $past(issue) && wr_addr_q == ins_q[25:21]) else $error("bad dest");
endmodule

// ### testbench/fpau_regfile.sv
// Purpose: register file model. Assumes: comb read. Notes: bench presets m.
`timescale 1ns/1ps
module fpau_regfile (
   // register file side
   input wire logic clk_sys, wr_en_q,
   input wire logic [4:0] rd_addr_a, rd_addr_b, wr_addr_q,
   input wire logic [31:0] wr_data_q,
   output logic [31:0] rd_data_a, rd_data_b
);
   logic [31:0] m [32];
   assign rd_data_a = m[rd_addr_a];
   assign rd_data_b = m[rd_addr_b];
   always @(posedge clk_sys) if (wr_en_q) m[wr_addr_q] <= wr_data_q;
endmodule

// ### testbench/fpau_top_bench.sv
// Purpose: directed tests. Assumes: 40 MHz, sync reset. Notes: abs, add, irq.
`timescale 1ns/1ps
module fpau_top_bench;
   logic clk_sys = 1'h0, rst_n = 1'h0, issue = 1'h0, old_arch = 1'h1;
   logic ca_load = 1'h0, ca_value = 1'h1, status_rd = 1'h0;
   logic wr_en_q, illegal_q, unsigned_wrap_bit_q, signed_wrap_flag_q;
   logic summary_q, irq_q;
   logic [1:0] irq_mask = 2'h0;
   logic [3:0] cr0_q;
   logic [4:0] rd_addr_a, rd_addr_b, wr_addr_q;
   logic [31:0] instr = 32'h0, rd_data_a, rd_data_b, wr_data_q;
   logic [31:0] pre [4] = '{32'hffff_ffff, 32'h8000_0000, 32'h0004_0000,
      32'h0000_4000};
   int bad_count = 0, n_checks = 0;
   always #12.5 clk_sys = ~clk_sys;
   fpau_top i_fpau_top (.*);
   fpau_regfile i_fpau_regfile (.*);
   task automatic chk(string nm, logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // ca_load only ever lasts one cycle, dropped as the issue is raised
   task automatic op(int d, a, b, o, r, logic [8:0] x);
      @(posedge clk_sys);
      issue <= 1'h1;
      ca_load <= 1'h0;
      instr <= {fpau_pkg::PRIMARY_OP, 5'(d), 5'(a), 5'(b), 1'(o), x, 1'(r)};
      @(posedge clk_sys);
      issue <= 1'h0;
      #1;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #20000 bad_count++;
      summarize();
   end
   initial begin
      foreach (pre[i]) i_fpau_regfile.m[i + 1] = pre[i];
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'h1;
      op(10, 1, 0, 0, 1, fpau_pkg::EXT_ABS);
      chk("abs", wr_data_q, 32'h1);
      chk("abs write", wr_en_q, 32'h1);
      chk("dest", wr_addr_q, 32'ha);
      chk("cr0 abs", cr0_q, 32'h4);
      op(10, 2, 0, 1, 0, fpau_pkg::EXT_ABS);
      chk("abs min", wr_data_q, 32'h8000_0000);
      chk("abs wrap", signed_wrap_flag_q, 32'h1);
      chk("carry abs", unsigned_wrap_bit_q, 32'h0);
      $display("abs tests done");
      @(posedge clk_sys);
      ca_load <= 1'h1;
      op(11, 2, 2, 0, 0, fpau_pkg::EXT_ADD);
      chk("oe off", signed_wrap_flag_q, 32'h1);
      op(11, 3, 4, 1, 1, fpau_pkg::EXT_ADD);
      chk("sum", wr_data_q, 32'h0004_4000);
      chk("oe on", signed_wrap_flag_q, 32'h0);
      chk("cr0", cr0_q, 32'h5);
      chk("carry", unsigned_wrap_bit_q, 32'h1);
      $display("add tests done");
      @(posedge clk_sys);
      old_arch <= 1'h0;
      op(12, 1, 0, 0, 0, fpau_pkg::EXT_ABS);
      chk("illegal", illegal_q, 32'h1);
      chk("no write", wr_en_q, 32'h0);
      // masks 2,1,0 then 3 with a status read
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys);
         irq_mask <= 2'(2 - k);
         status_rd <= 1'(k == 3);
         @(posedge clk_sys);
         status_rd <= 1'h0;
         repeat (2) @(posedge clk_sys);
         #1 chk("irq", irq_q, 32'(k < 2));
      end
      $display("irq tests done");
      summarize();
   end
endmodule
bind fpau_top fpau_chk i_fpau_chk (.*);
